// *** rtl/ptc_pkg.sv ***
// constants of the pin, timer and port-change interrupt block
package ptc_pkg;
	localparam logic [7:0] OFS_MAIN = 8'h00;
	localparam logic [7:0] OFS_SECOND = 8'h04;
	localparam logic [7:0] OFS_THIRD = 8'h08;
	localparam logic [7:0] OFS_G6_FLAG = 8'h0C;
	localparam logic [7:0] OFS_G6_EN = 8'h10;
	localparam logic [7:0] OFS_G6_PRI = 8'h14;
	localparam logic [7:0] OFS_TIMER = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_MASK = 8'h20;
	// interrupt_control_main bits
	localparam int MAIN_HIGH_EN = 7;
	localparam int MAIN_LOW_EN = 6;
	localparam int MAIN_T0_EN = 5;
	localparam int MAIN_P0_EN = 4;
	localparam int MAIN_PC_EN = 3;
	localparam int MAIN_T0_FLAG = 2;
	localparam int MAIN_P0_FLAG = 1;
	localparam int MAIN_PC_FLAG = 0;
	// second_irq_control bits; edge select of pin n at SEC_EDGE_LSB + n
	localparam int SEC_EDGE_LSB = 4;
	localparam int SEC_T0_16BIT = 3;
	localparam int SEC_T0_PRI = 2;
	localparam int SEC_P3_PRI = 1;
	localparam int SEC_PC_PRI = 0;
	// third_irq_control bits; pin n enable at THR_EN_LSB+n-1, flag at n-1
	localparam int THR_P2_PRI = 7;
	localparam int THR_P1_PRI = 6;
	localparam int THR_EN_LSB = 3;
	// group-6 layout
	localparam int G6_NVM = 4;
	localparam logic [7:0] G6_IMPL = 8'h17;
	localparam logic [7:0] MAIN_RST = 8'h00;
	localparam logic [7:0] SECOND_RST = 8'hF7;
	localparam logic [7:0] THIRD_RST = 8'hC0;
	localparam logic [7:0] G6_PRI_RST = 8'h17;
	localparam int PC_W = 21;
	localparam logic [20:0] VEC_HIGH = 21'h000008;
	localparam logic [20:0] VEC_LOW = 21'h000018;
	// sticky event status bits
	localparam int ST_W = 3;
	localparam int ST_WAKE = 0;
	localparam int ST_HIGH = 1;
	localparam int ST_LOW = 2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// *** rtl/ptc_irq_ctrl.sv ***
// interrupt source, priority, wake and context-save logic with AHB-Lite registers
`timescale 1ns/10ps
module ptc_irq_ctrl #(
	parameter int STACK_DEPTH = 31
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [3:0] ext_pin,
	input wire logic [3:0] port_b_hi,
	input wire logic timer_tick,
	input wire logic nvm_write_evt,
	input wire logic [2:0] comparator_evt,
	input wire logic sleep_mode,
	input wire logic core_ack,
	input wire logic core_ret,
	input wire logic [20:0] pc_in,
	input wire logic [7:0] working_register_in,
	input wire logic [7:0] status_in,
	input wire logic [7:0] bsr_in,
	output logic hi_req,
	output logic lo_req,
	output logic vector_go,
	output logic wake,
	output logic [20:0] vector_addr,
	output logic [20:0] stack_top,
	output logic [7:0] fast_working_register,
	output logic [7:0] fast_status,
	output logic [7:0] fast_bsr,
	output logic irq
);
	localparam int SP_W = $clog2(STACK_DEPTH + 1);

	function automatic logic hit(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
		hit = pend && (a == ofs);
	endfunction

	logic wr_pend;
	logic [7:0] wr_addr;
	logic rd_take;
	logic [31:0] rd_val;
	logic [7:0] int_main;
	logic [7:0] second_ctl;
	logic [7:0] third_ctl;
	logic [7:0] g6_flag;
	logic [7:0] g6_en;
	logic [7:0] g6_pri;
	logic [15:0] tmr;
	logic [ptc_pkg::ST_W-1:0] ev_status;
	logic [ptc_pkg::ST_W-1:0] ev_mask;
	logic [3:0] pin_s1, pin_s2, pin_s3;
	logic [3:0] pb_s1, pb_s2, pb_s3;
	logic [3:0] pin_edge;
	logic port_chg;
	logic t0_ovf;
	logic mode16;
	logic [5:0] pend_core;
	logic [5:0] pri_core;
	logic [7:0] pend_g6;
	logic wake_q;
	logic [SP_W-1:0] sp;
	logic [20:0] stack_mem [STACK_DEPTH];

	// bus slave: zero wait, stalls only while the clock enable is low
	assign hreadyout = clk_en;
	assign hresp = 1'b0;
	assign rd_take = hsel && hready && htrans[1] && !hwrite;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (clk_en) begin
			wr_pend <= hsel && hready && htrans[1] && hwrite && (hsize == ptc_pkg::HSIZE_WORD);
			wr_addr <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
		end
	end

	always_comb begin
		rd_val = 32'h00000000;
		if (haddr[31:8] == 24'h000000) begin
			case (haddr[7:0])
				ptc_pkg::OFS_MAIN: rd_val[7:0] = int_main;
				ptc_pkg::OFS_SECOND: rd_val[7:0] = second_ctl;
				ptc_pkg::OFS_THIRD: rd_val[7:0] = third_ctl;
				ptc_pkg::OFS_G6_FLAG: rd_val[7:0] = g6_flag;
				ptc_pkg::OFS_G6_EN: rd_val[7:0] = g6_en;
				ptc_pkg::OFS_G6_PRI: rd_val[7:0] = g6_pri;
				ptc_pkg::OFS_TIMER: rd_val[15:0] = tmr;
				ptc_pkg::OFS_STATUS: rd_val[ptc_pkg::ST_W-1:0] = ev_status;
				ptc_pkg::OFS_MASK: rd_val[ptc_pkg::ST_W-1:0] = ev_mask;
				default: rd_val = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else if (clk_en && rd_take) begin
			hrdata <= rd_val;
		end
	end

	// two-stage synchronisers, third stage only for edge detection
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			pin_s3 <= 4'h0;
			pb_s1 <= 4'h0;
			pb_s2 <= 4'h0;
			pb_s3 <= 4'h0;
		end else if (clk_en) begin
			pin_s1 <= ext_pin;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pb_s1 <= port_b_hi;
			pb_s2 <= pb_s1;
			pb_s3 <= pb_s2;
		end
	end

	always_comb begin
		for (int n = 0; n < 4; n++) begin
			pin_edge[n] = second_ctl[ptc_pkg::SEC_EDGE_LSB + n] ?
				(pin_s2[n] && !pin_s3[n]) : (!pin_s2[n] && pin_s3[n]);
		end
	end
	assign port_chg = (pb_s2 != pb_s3);

	// timer: 8-bit mode wraps the low byte only
	assign mode16 = second_ctl[ptc_pkg::SEC_T0_16BIT];
	assign t0_ovf = timer_tick && !hit(wr_pend, wr_addr, ptc_pkg::OFS_TIMER) &&
		(mode16 ? (tmr == 16'hFFFF) : (tmr[7:0] == 8'hFF));

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tmr <= 16'h0000;
		end else if (clk_en) begin
			if (hit(wr_pend, wr_addr, ptc_pkg::OFS_TIMER)) begin
				tmr <= hwdata[15:0];
			end else if (timer_tick) begin
				if (mode16) begin
					tmr <= tmr + 16'h0001;
				end else begin
					tmr <= {tmr[15:8], tmr[7:0] + 8'h01};
				end
			end
		end
	end

	// flags: hardware set wins over a software write in the same cycle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			int_main <= ptc_pkg::MAIN_RST;
		end else if (clk_en) begin
			int_main <= (hit(wr_pend, wr_addr, ptc_pkg::OFS_MAIN) ? hwdata[7:0] : int_main) |
				{5'h00, t0_ovf, pin_edge[0], port_chg};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			second_ctl <= ptc_pkg::SECOND_RST;
		end else if (clk_en && hit(wr_pend, wr_addr, ptc_pkg::OFS_SECOND)) begin
			second_ctl <= hwdata[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			third_ctl <= ptc_pkg::THIRD_RST;
		end else if (clk_en) begin
			third_ctl <= (hit(wr_pend, wr_addr, ptc_pkg::OFS_THIRD) ? hwdata[7:0] : third_ctl) |
				{5'h00, pin_edge[3:1]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			g6_flag <= 8'h00;
			g6_en <= 8'h00;
			g6_pri <= ptc_pkg::G6_PRI_RST;
		end else if (clk_en) begin
			g6_flag <= ((hit(wr_pend, wr_addr, ptc_pkg::OFS_G6_FLAG) ? hwdata[7:0] : g6_flag) |
				{3'h0, nvm_write_evt, 1'b0, comparator_evt}) & ptc_pkg::G6_IMPL;
			if (hit(wr_pend, wr_addr, ptc_pkg::OFS_G6_EN)) begin
				g6_en <= hwdata[7:0] & ptc_pkg::G6_IMPL;
			end
			if (hit(wr_pend, wr_addr, ptc_pkg::OFS_G6_PRI)) begin
				g6_pri <= hwdata[7:0] & ptc_pkg::G6_IMPL;
			end
		end
	end

	// sources: {timer, port change, pin3, pin2, pin1, pin0}
	assign pend_core = {
		int_main[ptc_pkg::MAIN_T0_FLAG] && int_main[ptc_pkg::MAIN_T0_EN],
		int_main[ptc_pkg::MAIN_PC_FLAG] && int_main[ptc_pkg::MAIN_PC_EN],
		third_ctl[2:0] & third_ctl[ptc_pkg::THR_EN_LSB +: 3],
		int_main[ptc_pkg::MAIN_P0_FLAG] && int_main[ptc_pkg::MAIN_P0_EN]};
	assign pri_core = {
		second_ctl[ptc_pkg::SEC_T0_PRI],
		second_ctl[ptc_pkg::SEC_PC_PRI],
		second_ctl[ptc_pkg::SEC_P3_PRI],
		third_ctl[ptc_pkg::THR_P2_PRI],
		third_ctl[ptc_pkg::THR_P1_PRI],
		1'b1};
	assign pend_g6 = g6_flag & g6_en;

	assign hi_req = int_main[ptc_pkg::MAIN_HIGH_EN] &&
		((|(pend_core & pri_core)) || (|(pend_g6 & g6_pri)));
	assign lo_req = int_main[ptc_pkg::MAIN_HIGH_EN] && int_main[ptc_pkg::MAIN_LOW_EN] &&
		((|(pend_core & ~pri_core)) || (|(pend_g6 & ~g6_pri)));
	assign vector_go = hi_req || lo_req;
	assign wake = sleep_mode && ((|pend_core) || (|pend_g6));

	// entry: vector, return address push and fast context copy
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			vector_addr <= ptc_pkg::VEC_HIGH;
			fast_working_register <= 8'h00;
			fast_status <= 8'h00;
			fast_bsr <= 8'h00;
		end else if (clk_en && core_ack) begin
			vector_addr <= hi_req ? ptc_pkg::VEC_HIGH : ptc_pkg::VEC_LOW;
			fast_working_register <= working_register_in;
			fast_status <= status_in;
			fast_bsr <= bsr_in;
		end
	end

	// a push onto a full stack is dropped
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sp <= '0;
		end else if (clk_en) begin
			if (core_ack) begin
				if (sp < SP_W'(STACK_DEPTH)) begin
					stack_mem[sp] <= pc_in;
					sp <= sp + 1'b1;
				end
			end else if (core_ret && sp != '0) begin
				sp <= sp - 1'b1;
			end
		end
	end
	assign stack_top = (sp == '0) ? 21'h000000 : stack_mem[SP_W'(sp - 1'b1)];

	// event status, write one to clear, set wins
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wake_q <= 1'b0;
			ev_status <= '0;
			ev_mask <= '0;
		end else if (clk_en) begin
			wake_q <= wake;
			ev_status <= (ev_status & ~(hit(wr_pend, wr_addr, ptc_pkg::OFS_STATUS) ?
				hwdata[ptc_pkg::ST_W-1:0] : 3'h0)) |
				{core_ack && !hi_req, core_ack && hi_req, wake && !wake_q};
			if (hit(wr_pend, wr_addr, ptc_pkg::OFS_MASK)) begin
				ev_mask <= hwdata[ptc_pkg::ST_W-1:0];
			end
		end
	end
	assign irq = |(ev_status & ev_mask);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	pin_edge_flag_a: assert property (
		clk_en && pin_edge[0] |=> int_main[ptc_pkg::MAIN_P0_FLAG])
		else $error("pin zero edge did not set its flag");
	rise_select_a: assert property (
		clk_en && second_ctl[ptc_pkg::SEC_EDGE_LSB + 1] && pin_s2[1] && !pin_s3[1]
		|=> third_ctl[0])
		else $error("rising edge of pin one missed");
	timer_wrap_a: assert property (
		clk_en && t0_ovf && !mode16 |=> int_main[ptc_pkg::MAIN_T0_FLAG] && tmr[7:0] == 8'h00)
		else $error("timer wrap did not set flag or clear count");
	port_change_a: assert property (
		clk_en && $changed(pb_s2) |=> int_main[ptc_pkg::MAIN_PC_FLAG])
		else $error("port change flag not set");
	pin0_high_a: assert property (
		int_main[ptc_pkg::MAIN_P0_FLAG] && int_main[ptc_pkg::MAIN_P0_EN]
		&& int_main[ptc_pkg::MAIN_HIGH_EN] |-> hi_req)
		else $error("pin zero not high priority");
	flag_hold_a: assert property (
		clk_en && int_main[ptc_pkg::MAIN_P0_FLAG] && !wr_pend |=> int_main[ptc_pkg::MAIN_P0_FLAG])
		else $error("flag dropped without software clear");
	wake_gate_a: assert property (
		wake && !int_main[ptc_pkg::MAIN_HIGH_EN] |-> !vector_go)
		else $error("vectoring while global enable clear");
	vector_low_a: assert property (
		clk_en && core_ack && !hi_req |=> vector_addr == ptc_pkg::VEC_LOW)
		else $error("low vector not loaded");
	context_save_a: assert property (
		clk_en && core_ack && sp < SP_W'(STACK_DEPTH)
		|=> fast_bsr == $past(bsr_in) && stack_top == $past(pc_in))
		else $error("context not saved on entry");
	g6_unimpl_a: assert property (
		(g6_flag & ~ptc_pkg::G6_IMPL) == 8'h00 && (g6_en & ~ptc_pkg::G6_IMPL) == 8'h00)
		else $error("unimplemented group-6 bit set");

	// edge, timer wrap, priority routing, wake, vector and stack checks
	fall_select_a: assert property (
		clk_en && !second_ctl[ptc_pkg::SEC_EDGE_LSB + 2] && !pin_s2[2] && pin_s3[2]
		|=> third_ctl[1])
		else $error("falling edge of pin two missed");
	edge_once_a: assert property (
		clk_en && pin_edge[0] && !wr_pend |=> !pin_edge[0])
		else $error("one pin edge seen twice");
	wrap_wide_a: assert property (
		clk_en && t0_ovf && mode16 |=> int_main[ptc_pkg::MAIN_T0_FLAG] && tmr == 16'h0000)
		else $error("16-bit timer wrap did not set flag or clear count");
	pin1_low_a: assert property (
		third_ctl[0] && third_ctl[ptc_pkg::THR_EN_LSB] && !third_ctl[ptc_pkg::THR_P1_PRI]
		&& int_main[ptc_pkg::MAIN_HIGH_EN] && int_main[ptc_pkg::MAIN_LOW_EN] |-> lo_req)
		else $error("pin one low priority request missing");
	pin3_high_a: assert property (
		third_ctl[2] && third_ctl[ptc_pkg::THR_EN_LSB + 2] && second_ctl[ptc_pkg::SEC_P3_PRI]
		&& int_main[ptc_pkg::MAIN_HIGH_EN] |-> hi_req)
		else $error("pin three high priority request missing");
	timer_gate_a: assert property (
		!int_main[ptc_pkg::MAIN_T0_EN] && pend_core[4:0] == 5'h00 && pend_g6 == 8'h00
		|-> !vector_go)
		else $error("timer request without its enable");
	change_pri_a: assert property (
		int_main[ptc_pkg::MAIN_PC_FLAG] && int_main[ptc_pkg::MAIN_PC_EN]
		&& second_ctl[ptc_pkg::SEC_PC_PRI] && int_main[ptc_pkg::MAIN_HIGH_EN] |-> hi_req)
		else $error("port change high priority request missing");
	pin_wake_a: assert property (
		sleep_mode && int_main[ptc_pkg::MAIN_P0_FLAG] && int_main[ptc_pkg::MAIN_P0_EN]
		|-> wake)
		else $error("enabled pin zero did not wake the core");
	wake_status_a: assert property (
		clk_en && wake && !wake_q |=> ev_status[ptc_pkg::ST_WAKE])
		else $error("wake event not recorded");
	vector_high_a: assert property (
		clk_en && core_ack && hi_req |=> vector_addr == ptc_pkg::VEC_HIGH)
		else $error("high vector not loaded");
	stack_pop_a: assert property (
		clk_en && core_ret && !core_ack && sp != '0 |=> sp == SP_W'($past(sp) - 1'b1))
		else $error("return did not pop the stack");
	g6_pri_impl_a: assert property (
		(g6_pri & ~ptc_pkg::G6_IMPL) == 8'h00)
		else $error("unimplemented group-6 priority bit set");
endmodule

// *** sim/ptc_core_model.sv ***
// processor core model: acknowledges a pending request once per arming
`timescale 1ns/10ps
module ptc_core_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic vector_go,
	input wire logic arm,
	input wire logic slow,
	output logic core_ack,
	output logic [20:0] pc_in,
	output logic [7:0] working_register_in,
	output logic [7:0] status_in,
	output logic [7:0] bsr_in
);
	logic [3:0] cnt;
	logic done;
	// context only valid in the ack cycle, inverted otherwise
	assign pc_in = core_ack ? 21'h001234 : ~21'h001234;
	assign working_register_in = core_ack ? 8'h5A : 8'hA5;
	assign status_in = core_ack ? 8'h3C : 8'hC3;
	assign bsr_in = core_ack ? 8'h07 : 8'hF8;
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !arm) begin
			cnt <= 4'h0;
			done <= 1'b0;
			core_ack <= 1'b0;
		end else begin
			core_ack <= 1'b0;
			if (vector_go && !done) begin
				cnt <= cnt + 4'h1;
				if (cnt == (slow ? 4'h4 : 4'h0)) begin
					core_ack <= 1'b1;
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// *** sim/test_pin_timer_change_interrupts.sv ***
// self-checking bench of the pin, timer and port-change interrupt block
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_pin_timer_change_interrupts;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0] ext_pin = 4'h0;
	logic [3:0] port_b_hi = 4'h0;
	logic timer_tick = 1'b0;
	logic nvm_write_evt = 1'b0;
	logic [2:0] comparator_evt = 3'h0;
	logic sleep_mode = 1'b0;
	logic core_ret = 1'b0;
	logic arm = 1'b0;
	logic slow = 1'b0;
	logic clk_en = 1'b1;
	logic [31:0] hrdata;
	logic hreadyout, hresp, hi_req, lo_req, vector_go, wake, irq, core_ack;
	logic [20:0] vector_addr, stack_top, pc_in;
	logic [7:0] fast_working_register, fast_status, fast_bsr, working_register_in, status_in, bsr_in;
	int fails = 0;
	int checks_done = 0;
	always #2 ref_clk = ~ref_clk;
	ptc_irq_ctrl u_ptc_irq_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .ext_pin(ext_pin), .port_b_hi(port_b_hi), .timer_tick(timer_tick),
		.nvm_write_evt(nvm_write_evt), .comparator_evt(comparator_evt),
		.sleep_mode(sleep_mode), .core_ack(core_ack), .core_ret(core_ret), .pc_in(pc_in),
		.working_register_in(working_register_in), .status_in(status_in), .bsr_in(bsr_in), .hi_req(hi_req),
		.lo_req(lo_req), .vector_go(vector_go), .wake(wake), .vector_addr(vector_addr),
		.stack_top(stack_top), .fast_working_register(fast_working_register), .fast_status(fast_status),
		.fast_bsr(fast_bsr), .irq(irq));
	ptc_core_model u_ptc_core_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.vector_go(vector_go), .arm(arm), .slow(slow), .core_ack(core_ack),
		.pc_in(pc_in), .working_register_in(working_register_in), .status_in(status_in), .bsr_in(bsr_in));
	task close_out;
		$display("comparisons %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			fails++;
			close_out;
		end
	endtask
	task aph(input logic [7:0] a, input logic w);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		aph(a, 1'b1);
		hwdata <= d;
		rdy;
	endtask
	task ck(input logic [7:0] a, input logic [31:0] e);
		aph(a, 1'b0);
		rdy;
		`CHK(hrdata, e)
	endtask
	task tick;
		@(posedge ref_clk);
		timer_tick <= 1'b1;
		@(posedge ref_clk);
		timer_tick <= 1'b0;
		cyc(2);
	endtask
	task t_regs;
		ck(ptc_pkg::OFS_MAIN, 32'h0);
		ck(ptc_pkg::OFS_SECOND, 32'hF7);
		ck(ptc_pkg::OFS_THIRD, 32'hC0);
		ck(ptc_pkg::OFS_G6_PRI, 32'h17);
		wr(ptc_pkg::OFS_G6_EN, 32'hFF);
		ck(ptc_pkg::OFS_G6_EN, 32'h17);
		nvm_write_evt <= 1'b1;
		comparator_evt <= 3'h7;
		@(posedge ref_clk);
		nvm_write_evt <= 1'b0;
		comparator_evt <= 3'h0;
		ck(ptc_pkg::OFS_G6_FLAG, 32'h17);
		wr(8'h40, 32'hFF);
		ck(8'h40, 32'h0);
		`CHK(hresp, 1'b0)
		wr(ptc_pkg::OFS_G6_EN, 32'h0);
		wr(ptc_pkg::OFS_G6_FLAG, 32'h0);
	endtask
	task t_pins;
		ext_pin <= 4'hF;
		cyc(6);
		ck(ptc_pkg::OFS_MAIN, 32'h02);
		ck(ptc_pkg::OFS_THIRD, 32'hC7);
		wr(ptc_pkg::OFS_MAIN, 32'h0);
		wr(ptc_pkg::OFS_THIRD, 32'hC0);
		cyc(6);
		ck(ptc_pkg::OFS_THIRD, 32'hC0);
		wr(ptc_pkg::OFS_SECOND, 32'h07);
		ext_pin <= 4'h0;
		port_b_hi <= 4'h4;
		cyc(6);
		ck(ptc_pkg::OFS_MAIN, 32'h03);
		ck(ptc_pkg::OFS_THIRD, 32'hC7);
		wr(ptc_pkg::OFS_MAIN, 32'h0);
		wr(ptc_pkg::OFS_THIRD, 32'hC0);
		wr(ptc_pkg::OFS_SECOND, 32'hF7);
	endtask
	task t_timer;
		wr(ptc_pkg::OFS_TIMER, 32'hFF);
		tick;
		ck(ptc_pkg::OFS_MAIN, 32'h04);
		wr(ptc_pkg::OFS_MAIN, 32'h0);
		wr(ptc_pkg::OFS_SECOND, 32'hFF);
		wr(ptc_pkg::OFS_TIMER, 32'hFF);
		tick;
		ck(ptc_pkg::OFS_MAIN, 32'h0);
		wr(ptc_pkg::OFS_TIMER, 32'hFFFF);
		tick;
		ck(ptc_pkg::OFS_MAIN, 32'h04);
		ck(ptc_pkg::OFS_TIMER, 32'h0);
		wr(ptc_pkg::OFS_SECOND, 32'hF3);
	endtask
	task t_req;
		wr(ptc_pkg::OFS_MAIN, 32'hA4);
		cyc(1);
		`CHK({hi_req, lo_req}, 2'b00)
		wr(ptc_pkg::OFS_MAIN, 32'hE4);
		cyc(1);
		`CHK({hi_req, lo_req}, 2'b01)
		slow <= 1'b1;
		arm <= 1'b1;
		cyc(10);
		`CHK(vector_addr, ptc_pkg::VEC_LOW)
		`CHK({fast_working_register, fast_status, fast_bsr}, 24'h5A3C07)
		`CHK(stack_top, 21'h001234)
		ck(ptc_pkg::OFS_MAIN, 32'hE4);
		arm <= 1'b0;
		core_ret <= 1'b1;
		@(posedge ref_clk);
		core_ret <= 1'b0;
		cyc(2);
		`CHK(stack_top, 21'h0)
		`CHK({fast_working_register, fast_status, fast_bsr}, 24'h5A3C07)
		wr(ptc_pkg::OFS_SECOND, 32'hF7);
		cyc(1);
		`CHK({hi_req, lo_req}, 2'b10)
		wr(ptc_pkg::OFS_MAIN, 32'h0);
	endtask
	task t_wake;
		// flag cleared above before the pin interrupt is enabled
		wr(ptc_pkg::OFS_MAIN, 32'h10);
		sleep_mode <= 1'b1;
		ext_pin <= 4'h1;
		cyc(6);
		`CHK({wake, vector_go}, 2'b10)
		ck(ptc_pkg::OFS_STATUS, 32'h5);
		wr(ptc_pkg::OFS_MASK, 32'h1);
		cyc(1);
		`CHK(irq, 1'b1)
		wr(ptc_pkg::OFS_STATUS, 32'h1);
		cyc(1);
		`CHK(irq, 1'b0)
		wr(ptc_pkg::OFS_SECOND, 32'hF0);
		wr(ptc_pkg::OFS_MAIN, 32'h92);
		cyc(1);
		`CHK({hi_req, lo_req}, 2'b10)
		slow <= 1'b0;
		arm <= 1'b1;
		cyc(4);
		`CHK(vector_addr, ptc_pkg::VEC_HIGH)
		arm <= 1'b0;
		sleep_mode <= 1'b0;
	endtask
	task t_freeze;
		// ticks while the clock enable is low must not move the count
		wr(ptc_pkg::OFS_TIMER, 32'hFE);
		clk_en <= 1'b0;
		timer_tick <= 1'b1;
		cyc(3);
		`CHK(hreadyout, 1'b0)
		clk_en <= 1'b1;
		timer_tick <= 1'b0;
		ck(ptc_pkg::OFS_TIMER, 32'hFE);
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_regs;
		t_pins;
		t_timer;
		t_req;
		t_wake;
		t_freeze;
		close_out;
	end
endmodule
